// ===== logic/pecint_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes word-aligned Wishbone byte addresses below 0x100
`ifndef PECINT_REGS_SVH
`define PECINT_REGS_SVH

// Byte offsets of the registers
`define PECINT_ADR_PA_RISE 8'h00
`define PECINT_ADR_PA_FALL 8'h04
`define PECINT_ADR_PA_FLAG 8'h08
`define PECINT_ADR_PB_RISE 8'h0c
`define PECINT_ADR_PB_FALL 8'h10
`define PECINT_ADR_PB_FLAG 8'h14
`define PECINT_ADR_CTRL 8'h18
`define PECINT_ADR_STAT 8'h1c
`define PECINT_ADR_ISTAT 8'h20
`define PECINT_ADR_IMASK 8'h24

// Implemented pin ranges
`define PECINT_PA_LO 0
`define PECINT_PA_HI 5
`define PECINT_PB_LO 4
`define PECINT_PB_HI 7

// Control and status fields
`define PECINT_CTRL_MEN 0
`define PECINT_STAT_SUM 0
`define PECINT_STAT_SLP 1

// Interrupt status fields
`define PECINT_IEV_PA 0
`define PECINT_IEV_PB 1
`define PECINT_IEV_WAKE 2
`define PECINT_IEV_W 3

// Reset values
`define PECINT_RST_BYTE 8'h00
`define PECINT_RST_IEV 3'h0

// Clocks per instruction cycle, less one
`define PECINT_QCYC_LAST 2'h3

`endif

// ===== logic/pecint_pkg.sv
// Types shared by the pin edge-change interrupt block
// Assumes a 32-bit classic Wishbone master
package pecint_pkg;

   // Wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } pecint_wb_req_s;

   // Bus access phase, one-hot
   typedef enum logic [1:0] {
      PECINT_BUS_IDLE = 2'h1,
      PECINT_BUS_ACK = 2'h2
   } pecint_bus_e;

endpackage

// ===== logic/pecint_edge_cell.sv
// One pin: synchroniser, instruction-cycle sampler, edge qualify, flag
// Assumes tick_i pulses once every instruction cycle
`timescale 1ns/1ps
module pecint_edge_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic pin_i,
   input wire logic rise_en_i,
   input wire logic fall_en_i,
   input wire logic wr_i,
   input wire logic wr_val_i,
   output logic flag_o,
   output logic hit_o
);
   logic sync1_ff;
   logic sync2_ff;
   logic samp_ff;
   logic vld_ff;
   logic flag_ff;
   logic nxt_flag;
   logic rise;
   logic fall;

   // Two-flop synchroniser
   always_ff @(posedge clk_i) begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
   end

   // Sample once per instruction cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         samp_ff <= 1'b0;
         vld_ff <= 1'b0;
      end else if (tick_i) begin
         samp_ff <= sync2_ff;
         vld_ff <= 1'b1;
      end
   end

   // Compare new sample with previous one, then qualify
   assign rise = tick_i & vld_ff & sync2_ff & ~samp_ff;
   assign fall = tick_i & vld_ff & ~sync2_ff & samp_ff;
   assign hit_o = (rise & rise_en_i) | (fall & fall_en_i);

   // Hardware set wins over a software write
   always_comb begin
      nxt_flag = wr_i ? wr_val_i : flag_ff;
      if (hit_o) begin
         nxt_flag = 1'b1;
      end
   end

   // Flag register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;
endmodule

// ===== logic/pecint_top.sv
// Pin edge-change interrupt block with Wishbone register slave
// Assumes pins are asynchronous inputs and clk_i keeps running in sleep
`timescale 1ns/1ps
`include "pecint_regs.svh"

module pecint_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pecint_pkg::pecint_wb_req_s wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [5:0] port_a_pin_i,
   input wire logic [7:4] port_b_pin_i,
   input wire logic sleep_i,
   output logic change_summary_flag_o,
   output logic change_irq_o,
   output logic wake_o,
   output logic irq_o
);

   // Registers
   logic [5:0] pa_rise_ff;
   logic [5:0] pa_fall_ff;
   logic [7:4] pb_rise_ff;
   logic [7:4] pb_fall_ff;
   logic men_ff;
   logic [`PECINT_IEV_W-1:0] istat_ff;
   logic [`PECINT_IEV_W-1:0] imask_ff;
   logic [1:0] qcnt_ff;
   logic [31:0] dat_ff;
   logic ack_ff;
   logic sum_ff;
   logic creq_ff;
   logic wake_ff;
   logic irq_ff;
   pecint_pkg::pecint_bus_e bus_ff;

   // Combinational
   logic tick;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] adr;
   logic hi_zero;
   logic [7:0] wbyte;
   logic [5:0] pa_flag;
   logic [7:4] pb_flag;
   logic [5:0] pa_hit;
   logic [7:4] pb_hit;
   logic pa_fwr;
   logic pb_fwr;
   logic sum;
   logic [`PECINT_IEV_W-1:0] iev;
   logic [`PECINT_IEV_W-1:0] nxt_istat;
   logic [31:0] nxt_dat;

   // Instruction cycle timing
   assign tick = (qcnt_ff == `PECINT_QCYC_LAST);

   // Quarter-cycle counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         qcnt_ff <= 2'h0;
      end else begin
         qcnt_ff <= qcnt_ff + 2'h1;
      end
   end

   // Bus decode
   assign acc = wb_req_i.cyc & wb_req_i.stb & (bus_ff == pecint_pkg::PECINT_BUS_IDLE);
   assign adr = wb_req_i.adr[7:0];
   assign hi_zero = (wb_req_i.adr[31:8] == 24'h0);
   assign wr = acc & wb_req_i.we & wb_req_i.sel[0] & hi_zero;
   assign rd = acc & ~wb_req_i.we & hi_zero;
   assign wbyte = wb_req_i.dat[7:0];

   // Flag write strobes
   assign pa_fwr = wr & (adr == `PECINT_ADR_PA_FLAG);
   assign pb_fwr = wr & (adr == `PECINT_ADR_PB_FLAG);

   // Port A pin cells
   genvar ga;
   generate
      for (ga = `PECINT_PA_LO; ga <= `PECINT_PA_HI; ga = ga + 1) begin : g_pa
         pecint_edge_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .pin_i(port_a_pin_i[ga]),
            .rise_en_i(pa_rise_ff[ga]),
            .fall_en_i(pa_fall_ff[ga]),
            .wr_i(pa_fwr),
            .wr_val_i(wbyte[ga]),
            .flag_o(pa_flag[ga]),
            .hit_o(pa_hit[ga])
         );
      end
   endgenerate

   // Port B pin cells
   genvar gb;
   generate
      for (gb = `PECINT_PB_LO; gb <= `PECINT_PB_HI; gb = gb + 1) begin : g_pb
         pecint_edge_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .pin_i(port_b_pin_i[gb]),
            .rise_en_i(pb_rise_ff[gb]),
            .fall_en_i(pb_fall_ff[gb]),
            .wr_i(pb_fwr),
            .wr_val_i(wbyte[gb]),
            .flag_o(pb_flag[gb]),
            .hit_o(pb_hit[gb])
         );
      end
   endgenerate

   // Summary of all pin flags
   assign sum = (|pa_flag) | (|pb_flag);

   // Port A enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_rise_ff <= 6'h00;
         pa_fall_ff <= 6'h00;
      end else begin
         if (wr && adr == `PECINT_ADR_PA_RISE) begin
            pa_rise_ff <= wbyte[5:0];
         end
         if (wr && adr == `PECINT_ADR_PA_FALL) begin
            pa_fall_ff <= wbyte[5:0];
         end
      end
   end

   // Port B enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pb_rise_ff <= 4'h0;
         pb_fall_ff <= 4'h0;
      end else begin
         if (wr && adr == `PECINT_ADR_PB_RISE) begin
            pb_rise_ff <= wbyte[7:4];
         end
         if (wr && adr == `PECINT_ADR_PB_FALL) begin
            pb_fall_ff <= wbyte[7:4];
         end
      end
   end

   // Master enable and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         men_ff <= 1'b0;
         imask_ff <= `PECINT_RST_IEV;
      end else begin
         if (wr && adr == `PECINT_ADR_CTRL) begin
            men_ff <= wbyte[`PECINT_CTRL_MEN];
         end
         if (wr && adr == `PECINT_ADR_IMASK) begin
            imask_ff <= wbyte[`PECINT_IEV_W-1:0];
         end
      end
   end

   // Events for the sticky status
   always_comb begin
      iev = `PECINT_RST_IEV;
      iev[`PECINT_IEV_PA] = |pa_hit;
      iev[`PECINT_IEV_PB] = |pb_hit;
      iev[`PECINT_IEV_WAKE] = sleep_i & men_ff & sum & ~wake_ff;
   end

   // Read clears status, a new event wins
   always_comb begin
      nxt_istat = istat_ff;
      if (rd && adr == `PECINT_ADR_ISTAT) begin
         nxt_istat = `PECINT_RST_IEV;
      end
      nxt_istat = nxt_istat | iev;
   end

   // Sticky status register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         istat_ff <= `PECINT_RST_IEV;
      end else begin
         istat_ff <= nxt_istat;
      end
   end

   // Core-facing outputs, detection runs regardless of enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sum_ff <= 1'b0;
         creq_ff <= 1'b0;
         wake_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         sum_ff <= sum;
         creq_ff <= men_ff & sum;
         wake_ff <= sleep_i & men_ff & sum;
         irq_ff <= |(istat_ff & imask_ff);
      end
   end

   // Read data mux, unused bits read zero
   always_comb begin
      nxt_dat = 32'h0;
      case (adr)
         `PECINT_ADR_PA_RISE: nxt_dat[5:0] = pa_rise_ff;
         `PECINT_ADR_PA_FALL: nxt_dat[5:0] = pa_fall_ff;
         `PECINT_ADR_PA_FLAG: nxt_dat[5:0] = pa_flag;
         `PECINT_ADR_PB_RISE: nxt_dat[7:4] = pb_rise_ff;
         `PECINT_ADR_PB_FALL: nxt_dat[7:4] = pb_fall_ff;
         `PECINT_ADR_PB_FLAG: nxt_dat[7:4] = pb_flag;
         `PECINT_ADR_CTRL: nxt_dat[`PECINT_CTRL_MEN] = men_ff;
         `PECINT_ADR_STAT: begin
            nxt_dat[`PECINT_STAT_SUM] = sum;
            nxt_dat[`PECINT_STAT_SLP] = sleep_i;
         end
         `PECINT_ADR_ISTAT: nxt_dat[`PECINT_IEV_W-1:0] = istat_ff;
         `PECINT_ADR_IMASK: nxt_dat[`PECINT_IEV_W-1:0] = imask_ff;
         default: nxt_dat = 32'h0;
      endcase
      if (!hi_zero) begin
         nxt_dat = 32'h0;
      end
   end

   // Bus phase: one ack per access, then a gap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_ff <= pecint_pkg::PECINT_BUS_IDLE;
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         case (bus_ff)
            pecint_pkg::PECINT_BUS_IDLE: begin
               if (acc) begin
                  bus_ff <= pecint_pkg::PECINT_BUS_ACK;
                  ack_ff <= 1'b1;
                  dat_ff <= wb_req_i.we ? 32'h0 : nxt_dat;
               end
            end
            pecint_pkg::PECINT_BUS_ACK: begin
               bus_ff <= pecint_pkg::PECINT_BUS_IDLE;
               ack_ff <= 1'b0;
            end
            default: begin
               bus_ff <= pecint_pkg::PECINT_BUS_IDLE;
               ack_ff <= 1'b0;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign wb_dat_o = dat_ff;
   assign wb_ack_o = ack_ff;
   assign change_summary_flag_o = sum_ff;
   assign change_irq_o = creq_ff;
   assign wake_o = wake_ff;
   assign irq_o = irq_ff;

endmodule

// ===== verification/pecint_chk_sva.sv
// Port checker for the pin edge-change block
// Assumes a bind onto pecint_top, one clock domain
`timescale 1ns/1ps
module pecint_chk_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pecint_pkg::pecint_wb_req_s wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [5:0] port_a_pin_i,
   input wire logic [7:4] port_b_pin_i,
   input wire logic sleep_i,
   input wire logic change_summary_flag_o,
   input wire logic change_irq_o,
   input wire logic wake_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [9:0] pins_ff;
   logic [3:0] quiet_ff;
   // Cycles since the last pin change, saturating
   always_ff @(posedge clk_i) begin
      pins_ff <= {port_a_pin_i, port_b_pin_i};
      if (rst_i) begin
         quiet_ff <= 4'hf;
      end else if ({port_a_pin_i, port_b_pin_i} != pins_ff) begin
         quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hf) begin
         quiet_ff <= quiet_ff + 4'h1;
      end
   end
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_ACK_REQ: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   AST_PB_ZERO: assert property (wb_ack_o && wb_req_i.adr[7:0] == 8'h14 |->
      wb_dat_o[31:8] == 24'h0 && wb_dat_o[3:0] == 4'h0)
      else $error("unused bits set");
   AST_IRQ_GATE: assert property (change_irq_o |-> change_summary_flag_o)
      else $error("request without flag");
   AST_WAKE: assert property (wake_o |-> change_irq_o && $past(sleep_i))
      else $error("bad wake");
   AST_SUM_FALL: assert property ($fell(change_summary_flag_o) |->
      $past(wb_req_i.we && wb_req_i.stb, 2))
      else $error("summary fell alone");
   AST_SUM_RISE: assert property ($rose(change_summary_flag_o) |-> quiet_ff < 4'h8)
      else $error("summary rose late");
   AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_req_i.cyc && wb_req_i.stb, 2))
      else $error("irq fell alone");
endmodule

// ===== verification/pecint_pin_model.sv
// Outside pins and core sleep state
// Assumes requests arrive just after a rising edge
`timescale 1ns/1ps
module pecint_pin_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] a_i,
   input wire logic [7:4] b_i,
   input wire logic nap_i,
   input wire logic wake_i,
   output logic [5:0] port_a_pin_o,
   output logic [7:4] port_b_pin_o,
   output logic sleep_o
);
   // Pins change just after an edge
   always_ff @(posedge clk_i) begin
      port_a_pin_o <= rst_i ? 6'h0 : a_i;
      port_b_pin_o <= rst_i ? 4'h0 : b_i;
   end
   // Core sleeps on request, leaves sleep once woken
   always_ff @(posedge clk_i) begin
      if (rst_i || wake_i) begin
         sleep_o <= 1'b0;
      end else if (nap_i) begin
         sleep_o <= 1'b1;
      end
   end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the pin edge-change block
// Assumes checker and pin model compiled first
`timescale 1ns/1ps
module testbench;
   logic clk, rst, nap, sleep, sum, cirq, wake, irq, ack;
   logic [5:0] a_set, pa;
   logic [7:4] b_set, pb;
   logic [31:0] dat;
   logic [7:0] rnd;
   logic [7:0] adr[4] = '{8'h00, 8'h04, 8'h0c, 8'h10};
   logic [7:0] msk[4] = '{8'h3f, 8'h3f, 8'hf0, 8'hf0};
   pecint_pkg::pecint_wb_req_s req;
   logic [31:0] expq[$];
   int failures, num_checks;
   pecint_top pecint_top_i (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat),
      .wb_ack_o(ack), .port_a_pin_i(pa), .port_b_pin_i(pb), .sleep_i(sleep),
      .change_summary_flag_o(sum), .change_irq_o(cirq), .wake_o(wake), .irq_o(irq));
   pecint_pin_model pecint_pin_model_i (.clk_i(clk), .rst_i(rst), .a_i(a_set), .b_i(b_set),
      .nap_i(nap), .wake_i(wake), .port_a_pin_o(pa), .port_b_pin_o(pb), .sleep_o(sleep));
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, w, 4'hf, {24'h0, a}, {24'h0, d}};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge clk);
      if (n >= 40) begin
         failures++;
         conclude();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back({24'h0, e});
      bus(1'b0, a, 8'h0);
   endtask
   // Set pins, let the sampler see them, read both flag words
   task automatic step(input logic [5:0] a, input logic [7:4] b, input logic [7:0] fa,
         input logic [7:0] fb);
      a_set <= a;
      b_set <= b;
      repeat (8) @(posedge clk);
      rd(8'h08, fa);
      rd(8'h14, fb);
   endtask
   // Invert the given flag words and AND back, writing zero
   task automatic clr(input logic [7:0] fa, input logic [7:0] fb);
      bus(1'b1, 8'h08, fa & (fa ^ 8'hff));
      bus(1'b1, 8'h14, fb & (fb ^ 8'hff));
   endtask
   // Read data against the oldest note
   always @(posedge clk) begin
      if (ack === 1'b1 && req.we === 1'b0) chk(dat, expq.pop_front());
   end
   initial begin
      int n;
      failures = 0;
      num_checks = 0;
      rst = 1'b1;
      nap = 1'b0;
      a_set = 6'h0;
      b_set = 4'h0;
      rnd = 8'h1f;
      req = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 11; i++) rd(8'(i * 4), 8'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         bus(1'b1, adr[i], rnd);
         rd(adr[i], rnd & msk[i]);
      end
      bus(1'b1, 8'h00, 8'h15);
      bus(1'b1, 8'h04, 8'h2a);
      bus(1'b1, 8'h0c, 8'h30);
      bus(1'b1, 8'h10, 8'hc0);
      step(6'h3f, 4'hf, 8'h15, 8'h30);
      chk(sum, 1'b1);
      chk(cirq, 1'b0);
      chk(irq, 1'b0);
      clr(8'h15, 8'h30);
      rd(8'h1c, 8'h00);
      step(6'h00, 4'h0, 8'h2a, 8'hc0);
      rd(8'h20, 8'h03);
      bus(1'b1, 8'h18, 8'h01);
      repeat (2) @(posedge clk);
      chk(cirq, 1'b1);
      clr(8'h2a, 8'hc0);
      bus(1'b1, 8'h24, 8'h07);
      // Sleep, then a rising edge on pin 0 wakes the core
      nap <= 1'b1;
      @(posedge clk);
      nap <= 1'b0;
      a_set <= 6'h01;
      repeat (2) @(posedge clk);
      for (n = 0; sleep === 1'b1 && n < 40; n++) @(posedge clk);
      chk(n < 40, 1'b1);
      rd(8'h08, 8'h01);
      chk(irq, 1'b1);
      rd(8'h20, 8'h05);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      conclude();
   end
endmodule
bind pecint_top pecint_chk_sva pecint_chk_sva_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .port_a_pin_i(port_a_pin_i), .port_b_pin_i(port_b_pin_i), .sleep_i(sleep_i),
   .change_summary_flag_o(change_summary_flag_o), .change_irq_o(change_irq_o),
   .wake_o(wake_o), .irq_o(irq_o));
